//--- src/hpslot_indicator.sv
// one slot indicator lamp driver with blink timer
module hpslot_indicator #(
  parameter int P_HALF_CYCLES = hpslot_pkg::BLINK_HALF_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_present,
  input  wire logic [1:0] i_cmd,
  output logic            o_lamp
);

  localparam int CW = (P_HALF_CYCLES > 1) ? $clog2(P_HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(P_HALF_CYCLES - 1);

  logic [CW-1:0] blink_count;
  logic          blink_phase;

  // free-running blink phase; all lamps blink in step
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      blink_count <= '0;
      blink_phase <= 1'b0;
    end else if (blink_count == LAST) begin
      blink_count <= '0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_count <= blink_count + CW'(1);
    end
  end

  // absent lamp stays dark; reserved code keeps the last level
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lamp <= 1'b0;
    end else if (!i_present) begin
      o_lamp <= 1'b0;
    end else begin
      case (i_cmd)
        hpslot_pkg::IND_ON:    o_lamp <= 1'b1;
        hpslot_pkg::IND_BLINK: o_lamp <= blink_phase;
        hpslot_pkg::IND_OFF:   o_lamp <= 1'b0;
        default:               o_lamp <= o_lamp;
      endcase
    end
  end

endmodule

//--- src/hpslot_pkg.sv
// constants for the slot hot-plug register logic
package hpslot_pkg;

  // configuration byte offsets, dword aligned
  localparam logic [7:0]  SLOT_CAP_ADDR   = 8'hb4;
  localparam logic [7:0]  SLOT_CTL_ADDR   = 8'hb8;

  // slot capabilities field positions
  localparam int          CAP_ABP_BIT     = 0;
  localparam int          CAP_PCP_BIT     = 1;
  localparam int          CAP_MSP_BIT     = 2;
  localparam int          CAP_AIP_BIT     = 3;
  localparam int          CAP_PIP_BIT     = 4;
  localparam int          CAP_HPC_BIT     = 6;

  // slot control field positions
  localparam int          CTL_HOTPLUG_IRQ_EN_BIT    = 5;
  localparam int          CTL_AIC_LO      = 6;
  localparam int          CTL_PIC_LO      = 8;
  localparam int          CTL_PCC_BIT     = 10;
  localparam int          CTL_EIC_BIT     = 11;
  localparam int          CTL_DLL_BIT     = 12;

  // slot control reset image and per-field reset values
  localparam logic [15:0] CTL_RESET       = 16'h01c0;
  localparam logic [1:0]  PIC_RESET       = 2'h1;
  localparam logic [1:0]  AIC_RESET       = 2'h3;
  localparam logic        PCC_RESET       = 1'h0;
  localparam logic        HOTPLUG_IRQ_EN_RESET      = 1'h0;
  localparam logic        DLL_RESET       = 1'h0;

  // indicator command encoding
  localparam logic [1:0]  IND_RESERVED    = 2'h0;
  localparam logic [1:0]  IND_ON          = 2'h1;
  localparam logic [1:0]  IND_BLINK       = 2'h2;
  localparam logic [1:0]  IND_OFF         = 2'h3;

  // power command encoding
  localparam logic        PCC_POWER_ON    = 1'h0;
  localparam logic        PCC_POWER_OFF   = 1'h1;

  // timing
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          BLINK_HALF_MS   = 500;
  localparam int          BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;

endpackage

//--- src/hpslot_regs.sv
// slot capabilities and slot control registers of one downstream port
//
// Summary of operation
// - capability bit 4: power indicator present, read-only
// - capability bit 3: attention indicator present, read-only
// - capability bit 2: latch sensor present, read-only
// - capability bit 1: power switch present, read-only
// - capability bit 0: attention button present, read-only
// - control bit 12: link change notify, writable only with link-active capability, else 0
// - control bit 11: write 1 toggles interlock, reads 0
// - control bit 10: 0 powers on, 1 off
// - command fields of present features read back last written value
// - no power switch: power command writes ignored
// - fault removes power regardless of command
// - control bits 9:8 power indicator, default on
// - control bits 7:6 attention indicator, default off
// - port drives present indicators directly
// - control bit 5 enables hot-plug interrupt
// - not hot-plug capable: interrupt enable reads 0
// - capability bit 6: hot-plug capable, read-only
module hpslot_regs #(
  parameter bit P_PWR_IND_PRESENT  = 1'b0,
  parameter bit P_ATTN_IND_PRESENT = 1'b0,
  parameter bit P_LATCH_SENSOR     = 1'b0,
  parameter bit P_PWR_SWITCH       = 1'b0,
  parameter bit P_ATTN_BUTTON      = 1'b0,
  parameter bit P_HOTPLUG_CAPABLE  = 1'b0,
  parameter bit P_LINK_ACTIVE_CAP  = 1'b0,
  parameter bit P_INTERLOCK        = 1'b0,
  parameter int P_BLINK_HALF_CYC   = hpslot_pkg::BLINK_HALF_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        i_power_fault,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  output logic             o_slot_power_on,
  output logic             o_interlock_toggle,
  output logic             o_pwr_indicator,
  output logic             o_attn_indicator,
  output logic             o_hotplug_irq_en,
  output logic             o_link_state_change_notify_en
);

  logic        slot_power_cmd;
  logic [1:0]  pwr_indicator_cmd;
  logic [1:0]  attn_indicator_cmd;
  logic        hotplug_irq_en;
  logic        link_state_change_notify_en;
  logic        rd_was_cap;
  logic        rd_was_ctl;

  logic        hit_cap;
  logic        hit_ctl;
  logic        ctl_wr_b0;
  logic        ctl_wr_b1;
  logic [31:0] cap_view;
  logic [15:0] ctl_view;
  logic [31:0] next_rdata;

  assign hit_cap   = (i_cfg_addr[7:2] == hpslot_pkg::SLOT_CAP_ADDR[7:2]);
  assign hit_ctl   = (i_cfg_addr[7:2] == hpslot_pkg::SLOT_CTL_ADDR[7:2]);
  assign ctl_wr_b0 = i_cfg_wr && hit_ctl && i_cfg_be[0];
  assign ctl_wr_b1 = i_cfg_wr && hit_ctl && i_cfg_be[1];

  // capability image built from strap parameters only
  always_comb begin
    cap_view = '0;
    cap_view[hpslot_pkg::CAP_PIP_BIT] = P_PWR_IND_PRESENT;
    cap_view[hpslot_pkg::CAP_AIP_BIT] = P_ATTN_IND_PRESENT;
    cap_view[hpslot_pkg::CAP_MSP_BIT] = P_LATCH_SENSOR;
    cap_view[hpslot_pkg::CAP_PCP_BIT] = P_PWR_SWITCH;
    cap_view[hpslot_pkg::CAP_ABP_BIT] = P_ATTN_BUTTON;
    cap_view[hpslot_pkg::CAP_HPC_BIT] = P_HOTPLUG_CAPABLE;
  end

  // control image; bits 4:0 and status live elsewhere
  always_comb begin
    ctl_view = '0;
    ctl_view[15:13] = 3'h0;
    ctl_view[hpslot_pkg::CTL_DLL_BIT] = link_state_change_notify_en;
    ctl_view[hpslot_pkg::CTL_EIC_BIT] = 1'b0;
    ctl_view[hpslot_pkg::CTL_PCC_BIT] = slot_power_cmd;
    ctl_view[hpslot_pkg::CTL_PIC_LO +: 2] = pwr_indicator_cmd;
    ctl_view[hpslot_pkg::CTL_AIC_LO +: 2] = attn_indicator_cmd;
    ctl_view[hpslot_pkg::CTL_HOTPLUG_IRQ_EN_BIT] = hotplug_irq_en;
  end

  always_comb begin
    if (hit_cap) begin
      next_rdata = cap_view;
    end else if (hit_ctl) begin
      next_rdata = {16'h0000, ctl_view};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // read data registered; unmapped dwords read zero
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
      rd_was_cap   <= 1'b0;
      rd_was_ctl   <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      rd_was_cap   <= i_cfg_rd && hit_cap;
      rd_was_ctl   <= i_cfg_rd && hit_ctl;
      if (i_cfg_rd) begin
        o_cfg_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slot_power_cmd <= hpslot_pkg::PCC_RESET;
    end else if (ctl_wr_b1 && P_PWR_SWITCH) begin
      slot_power_cmd <= i_cfg_wdata[hpslot_pkg::CTL_PCC_BIT];
    end
  end

  // power indicator command, writable only when present
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_indicator_cmd <= hpslot_pkg::PIC_RESET;
    end else if (ctl_wr_b1 && P_PWR_IND_PRESENT) begin
      pwr_indicator_cmd <= i_cfg_wdata[hpslot_pkg::CTL_PIC_LO +: 2];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      attn_indicator_cmd <= hpslot_pkg::AIC_RESET;
    end else if (ctl_wr_b0 && P_ATTN_IND_PRESENT) begin
      attn_indicator_cmd <= i_cfg_wdata[hpslot_pkg::CTL_AIC_LO +: 2];
    end
  end

  // held at zero when not hot-plug capable
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hotplug_irq_en <= hpslot_pkg::HOTPLUG_IRQ_EN_RESET;
    end else if (ctl_wr_b0 && P_HOTPLUG_CAPABLE) begin
      hotplug_irq_en <= i_cfg_wdata[hpslot_pkg::CTL_HOTPLUG_IRQ_EN_BIT];
    end
  end

  // link change notify, only with link-active capability
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link_state_change_notify_en <= hpslot_pkg::DLL_RESET;
    end else if (ctl_wr_b1 && P_LINK_ACTIVE_CAP) begin
      link_state_change_notify_en <= i_cfg_wdata[hpslot_pkg::CTL_DLL_BIT];
    end
  end

  // one-cycle toggle pulse per write of 1
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_interlock_toggle <= 1'b0;
    end else begin
      o_interlock_toggle <= ctl_wr_b1 && P_INTERLOCK && i_cfg_wdata[hpslot_pkg::CTL_EIC_BIT];
    end
  end

  // fault drops power and blocks power-up
  // switch absent: slot power is not ours to gate, so it stays on
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_slot_power_on <= 1'b0;
    end else if (i_power_fault) begin
      o_slot_power_on <= 1'b0;
    end else if (!P_PWR_SWITCH) begin
      o_slot_power_on <= 1'b1;
    end else begin
      o_slot_power_on <= (slot_power_cmd == hpslot_pkg::PCC_POWER_ON);
    end
  end

  assign o_hotplug_irq_en              = hotplug_irq_en;
  assign o_link_state_change_notify_en = link_state_change_notify_en;

  // port drives its own indicator lamps
  logic [1:0] lamp_present;
  logic [1:0] lamp_out;
  logic [3:0] lamp_cmd;

  assign lamp_present = {P_ATTN_IND_PRESENT, P_PWR_IND_PRESENT};
  assign lamp_cmd     = {attn_indicator_cmd, pwr_indicator_cmd};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lamp
      hpslot_indicator #(
        .P_HALF_CYCLES (P_BLINK_HALF_CYC)
      ) u_lamp (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_present (lamp_present[g]),
        .i_cmd     (lamp_cmd[2*g +: 2]),
        .o_lamp    (lamp_out[g])
      );
    end
  endgenerate

  assign o_pwr_indicator  = lamp_out[0];
  assign o_attn_indicator = lamp_out[1];

  // assertions

  property p_cap_bits;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_cfg_rvalid && rd_was_cap |-> o_cfg_rdata[4:0] ==
      {P_PWR_IND_PRESENT, P_ATTN_IND_PRESENT, P_LATCH_SENSOR, P_PWR_SWITCH, P_ATTN_BUTTON};
  endproperty
  a_cap_bits: assert property (p_cap_bits) else $error("capability presence bits wrong");

  property p_hpc_bit;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_cfg_rd && hit_cap |=> o_cfg_rvalid && (o_cfg_rdata[6] == P_HOTPLUG_CAPABLE);
  endproperty
  a_hpc_bit: assert property (p_hpc_bit) else $error("hot-plug capable bit wrong");

  property p_ctl_reserved;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_cfg_rvalid && rd_was_ctl |-> (o_cfg_rdata[15:13] == 3'h0) && (o_cfg_rdata[31:16] == 16'h0000);
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits not zero");

  property p_interlock_read;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_cfg_rd && hit_ctl |=> !o_cfg_rdata[11];
  endproperty
  a_interlock_read: assert property (p_interlock_read) else $error("interlock bit read as 1");

  property p_interlock_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_interlock_toggle |-> $past(ctl_wr_b1) && $past(i_cfg_wdata[11]) && P_INTERLOCK;
  endproperty
  a_interlock_pulse: assert property (p_interlock_pulse) else $error("spurious interlock toggle");

  property p_pwr_cmd_kept;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !P_PWR_SWITCH |-> slot_power_cmd == hpslot_pkg::PCC_RESET;
  endproperty
  a_pwr_cmd_kept: assert property (p_pwr_cmd_kept) else $error("power command changed");

  property p_readback;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    ctl_wr_b1 && P_PWR_SWITCH && !i_cfg_rd ##1 i_cfg_rd && hit_ctl && !i_cfg_wr
      |=> o_cfg_rdata[10] == $past(i_cfg_wdata[10], 2);
  endproperty
  a_readback: assert property (p_readback) else $error("power command readback wrong");

  property p_fault_off;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_power_fault |=> !o_slot_power_on;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("power on during fault");

  property p_irq_en_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !P_HOTPLUG_CAPABLE |-> !o_hotplug_irq_en;
  endproperty
  a_irq_en_zero: assert property (p_irq_en_zero) else $error("irq enable set without hot-plug");

  property p_link_en_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !P_LINK_ACTIVE_CAP |-> !o_link_state_change_notify_en;
  endproperty
  a_link_en_zero: assert property (p_link_en_zero) else $error("link notify set without cap");

  property p_ind_defaults;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_cfg_rd && hit_ctl && !P_PWR_IND_PRESENT && !P_ATTN_IND_PRESENT
      |=> o_cfg_rdata[9:6] == {hpslot_pkg::PIC_RESET, hpslot_pkg::AIC_RESET};
  endproperty
  a_ind_defaults: assert property (p_ind_defaults) else $error("indicator default lost");

endmodule

//--- tb/hpslot_slot_model.sv
// slot-side model: fault source, interlock latch, lamp timer
module hpslot_slot_model (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  input  wire logic i_fault_req,
  input  wire logic i_interlock_toggle,
  input  wire logic i_lamp,
  output logic      o_power_fault,
  output logic      o_interlock_state,
  output int        o_lamp_run
);
  timeunit 1ns;
  timeprecision 1ps;
  int   run;
  logic lamp_q;
  assign o_power_fault = i_fault_req;
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_interlock_state <= 1'b0;
    end else if (i_interlock_toggle === 1'b1) begin
      o_interlock_state <= ~o_interlock_state;
    end
  end
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lamp_q     <= 1'b0;
      run        <= 0;
      o_lamp_run <= 0;
    end else if (i_lamp !== lamp_q) begin
      lamp_q     <= i_lamp;
      o_lamp_run <= run;
      run <= 1;
    end else begin
      lamp_q <= i_lamp;
      run <= run + 1;
    end
  end
endmodule

//--- tb/tb_top.sv
// bench: bare slot and fully fitted slot on one config bus
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_b;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic        fault_req;
  logic        fault;
  logic [31:0] rdata [2];
  logic        rvalid [2];
  logic        pwr [2];
  logic        tog [2];
  logic        plamp [2];
  logic        alamp [2];
  logic        irq [2];
  logic        dll [2];
  logic        lock;
  int          run;
  int          n_mismatch;
  int          checked;
  logic [1:0]  codes [4];
  logic        lit [4];

  // index 0 bare slot, index 1 every feature fitted
  for (genvar i = 0; i < 2; i++) begin : g
    hpslot_regs #(
      .P_PWR_IND_PRESENT  (i == 1),
      .P_ATTN_IND_PRESENT (i == 1),
      .P_LATCH_SENSOR     (i == 1),
      .P_PWR_SWITCH       (i == 1),
      .P_ATTN_BUTTON      (i == 1),
      .P_HOTPLUG_CAPABLE  (i == 1),
      .P_LINK_ACTIVE_CAP  (i == 1),
      .P_INTERLOCK        (i == 1),
      .P_BLINK_HALF_CYC   (4)
    ) dut (
      .i_ref_clk                     (clk),
      .i_rst_b                       (rst_b),
      .i_cfg_wr                      (wr),
      .i_cfg_rd                      (rd),
      .i_cfg_addr                    (addr),
      .i_cfg_be                      (be),
      .i_cfg_wdata                   (wdata),
      .i_power_fault                 (fault),
      .o_cfg_rdata                   (rdata[i]),
      .o_cfg_rvalid                  (rvalid[i]),
      .o_slot_power_on               (pwr[i]),
      .o_interlock_toggle            (tog[i]),
      .o_pwr_indicator               (plamp[i]),
      .o_attn_indicator              (alamp[i]),
      .o_hotplug_irq_en              (irq[i]),
      .o_link_state_change_notify_en (dll[i])
    );
  end

  hpslot_slot_model slot (
    .i_ref_clk          (clk),
    .i_rst_b            (rst_b),
    .i_fault_req        (fault_req),
    .i_interlock_toggle (tog[1]),
    .i_lamp             (plamp[1]),
    .o_power_fault      (fault),
    .o_interlock_state  (lock),
    .o_lamp_run         (run)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cfg_write(logic [7:0] a, logic [3:0] b, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // answer is due on the same edge that takes the strobe
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e0, logic [31:0] e1);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rvalid", 32'({rvalid[1], rvalid[0]}), 32'h0000_0003);
    check({nm, " bare"}, rdata[0], e0);
    check({nm, " full"}, rdata[1], e1);
  endtask

  task automatic bits(string nm, logic s1, logic s0, logic [1:0] e);
    check(nm, 32'({s1, s0}), 32'(e));
  endtask

  initial begin
    #50_000;
    n_mismatch++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    be = 4'h0;
    wdata = 32'h0000_0000;
    fault_req = 1'b0;
    // reserved follows on, so holding the lit level shows
    codes = '{hpslot_pkg::IND_ON, hpslot_pkg::IND_RESERVED,
              hpslot_pkg::IND_OFF, hpslot_pkg::IND_BLINK};
    lit = '{1'b1, 1'b1, 1'b0, 1'b0};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("cap", 8'hb4, 32'h0000_0000, 32'h0000_005f);
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_01c0);
    rd_chk("gap", 8'h40, 32'h0000_0000, 32'h0000_0000);
    cfg_write(8'hb4, 4'hf, 32'hffff_ffff);
    rd_chk("cap", 8'hb4, 32'h0000_0000, 32'h0000_005f);
    cfg_write(8'hb8, 4'hf, 32'hffff_ffff);
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_17e0);
    check("lock", 32'(lock), 32'h0000_0001);
    bits("pwr", pwr[1], pwr[0], 2'h1);
    bits("irq", irq[1], irq[0], 2'h2);
    bits("dll", dll[1], dll[0], 2'h2);
    cfg_write(8'hb8, 4'h3, 32'h0000_0000);
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_0000);
    check("lock", 32'(lock), 32'h0000_0001);
    bits("pwr", pwr[1], pwr[0], 2'h3);
    // low byte lane only: upper control bits kept
    cfg_write(8'hb8, 4'h1, 32'hffff_ffff);
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_00e0);
    @(posedge clk);
    fault_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    bits("pwr", pwr[1], pwr[0], 2'h0);
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_00e0);
    @(posedge clk);
    fault_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    bits("pwr", pwr[1], pwr[0], 2'h3);
    foreach (codes[k]) begin
      cfg_write(8'hb8, 4'h3, {22'h00_0000, codes[k], codes[k], 6'h20});
      rd_chk("ind", 8'hb8, 32'h0000_01c0, {22'h00_0000, codes[k], codes[k], 6'h20});
      repeat (20) @(posedge clk);
      #1;
      if (codes[k] === hpslot_pkg::IND_BLINK) begin
        check("blink", 32'(run), 32'h0000_0004);
      end else begin
        bits("lamps", plamp[1], alamp[1], {lit[k], lit[k]});
      end
      bits("absent", plamp[0], alamp[0], 2'h0);
    end
    // read taken on the edge right after the write
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= 8'hb8;
    be    <= 4'h3;
    wdata <= 32'h0000_0400;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("wr rd full", rdata[1], 32'h0000_0400);
    check("wr rd bare", rdata[0], 32'h0000_01c0);
    bits("pwr", pwr[1], pwr[0], 2'h1);
    check("lock", 32'(lock), 32'h0000_0001);
    // mid-run reset restores defaults
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("ctl", 8'hb8, 32'h0000_01c0, 32'h0000_01c0);
    bits("pwr", pwr[1], pwr[0], 2'h3);
    close_out();
  end
endmodule
